// [design/sdram_bank_ctrl.sv]
`timescale 1ns/1ps
`include "sdram_defines.svh"

module sdram_bank_ctrl
  import sdram_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic activate,
  input wire logic precharge,
  input wire logic [11:0] row_in,
  output logic row_open,
  output logic idle,
  output logic [11:0] row_addr
);

  localparam logic [2:0] RP_W = 3'(`RP_CYC);

  bank_state_t state_q;
  logic [2:0] rp_cnt_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= BANK_IDLE;
      rp_cnt_q <= 3'h0;
      row_open <= 1'b0;
      idle <= 1'b1;
    end else begin
      case (state_q)
        BANK_IDLE: begin
          if (activate) begin
            state_q <= BANK_ACTIVE;
            row_open <= 1'b1;
            idle <= 1'b0;
          end
        end
        BANK_ACTIVE: begin
          if (precharge) begin
            row_open <= 1'b0;
            if (RP_W <= 3'h1) begin
              state_q <= BANK_IDLE;
              idle <= 1'b1;
            end else begin
              state_q <= BANK_PRECHARGING;
              rp_cnt_q <= RP_W - 3'h2;
            end
          end
        end
        BANK_PRECHARGING: begin
          if (rp_cnt_q == 3'h0) begin
            state_q <= BANK_IDLE;
            idle <= 1'b1;
          end else begin
            rp_cnt_q <= rp_cnt_q - 3'h1;
          end
        end
        default: begin
          state_q <= BANK_IDLE;
          idle <= 1'b1;
          row_open <= 1'b0;
        end
      endcase
    end
  end

  // Row latched on activate of an idle bank and held until the next such activate, not cleared when the bank closes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      row_addr <= 12'h000;
    end else if (activate && state_q == BANK_IDLE) begin
      row_addr <= row_in;
    end
  end

  AST_PRE_CLOSES: assert property (@(posedge clk) disable iff (!resetn)
    state_q == BANK_ACTIVE && precharge |=> !row_open)
    else $error("bank stayed open after precharge");

endmodule

// [design/sdram_command_protocol.sv]
// Summary of operation
// - Chip select high executes no new command
// - No-operation does nothing, ongoing work continues
// - Activate opens bank row until precharged
// - Read bursts from column, A10 autoprecharges after
// - Read data mask acts two clocks later
// - Write bursts from column, A10 autoprecharges after
// - Write lanes with mask high not stored
// - Precharge A10 high closes all banks
// - Precharged bank idle after precharge time
// - Burst terminate truncates latest read or write
// - Auto refresh uses internal row counter
// - Self refresh entered by refresh, clock-enable low
// - Self refresh runs internal refresh cycles
// - Automotive grade never enters self refresh
// - Command codes on select and three strobes
// - Column from A[7:0], row from A[11:0]
// - Refresh code: clock enable picks auto/self
`timescale 1ns/1ps
`include "sdram_defines.svh"

module sdram_command_protocol
  import sdram_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cke,
  input wire cmd_pins_t cmd,
  input wire logic [1:0] ba,
  input wire logic [11:0] addr,
  input wire logic [3:0] dqm,
  input wire logic [31:0] dq_in,
  input wire logic automotive_grade,
  output logic [31:0] dq_out,
  output logic [3:0] dq_oe_n,
  output logic self_refresh,
  output logic [11:0] refresh_row,
  output logic [13:0] mode_word,
  output logic [3:0] bank_open
);

  cmd_t cmd_dec;
  logic exec;
  logic sr_entry;
  logic [2:0] busy_q;
  logic [2:0] xsr_q;
  logic [8:0] sr_tmr_q;
  logic sr_tick;
  logic [3:0] bank_idle;
  logic [3:0] act_vec;
  logic [3:0] pre_vec;
  logic [11:0] bank_row [4];
  logic burst_on_q;
  logic burst_wr_q;
  logic burst_ap_q;
  logic [1:0] burst_bank_q;
  logic [7:0] burst_col_q;
  logic [8:0] burst_left_q;
  logic start;
  logic term;
  logic last;
  logic ap_fire;
  logic [8:0] len;
  logic wr_en;
  logic [`MEM_AW-1:0] wr_idx;
  logic [`MEM_AW-1:0] rd_idx;
  logic [31:0] rd_word;
  logic rd_v1_q;
  logic [31:0] rd_s1_q;
  logic [3:0] dqm_d1_q;
  logic [3:0] dqm_d2_q;

  // Command decode from select and strobes
  always_comb begin
    cmd_dec = CMD_DESELECT;
    if (!cmd.cs_n) begin
      case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
        3'h7: cmd_dec = CMD_NOP;
        3'h3: cmd_dec = CMD_ACTIVATE;
        3'h5: cmd_dec = CMD_READ;
        3'h4: cmd_dec = CMD_WRITE;
        3'h6: cmd_dec = CMD_TERMINATE;
        3'h2: cmd_dec = CMD_PRECHARGE;
        3'h1: cmd_dec = CMD_REFRESH;
        3'h0: cmd_dec = CMD_MODE_LOAD;
        default: cmd_dec = CMD_NOP;
      endcase
    end
  end

  assign exec = cke && !self_refresh && xsr_q == 3'h0 && busy_q == 3'h0;
  assign sr_entry = cmd_dec == CMD_REFRESH && !cke && !self_refresh && !automotive_grade &&
                    busy_q == 3'h0 && xsr_q == 3'h0;

  // Busy time after refresh or mode load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 3'h0;
    end else if (exec && cmd_dec == CMD_REFRESH) begin
      busy_q <= 3'(`RFC_CYC - 1);
    end else if (exec && cmd_dec == CMD_MODE_LOAD && bank_idle == 4'hF) begin
      busy_q <= 3'(`MRD_CYC - 1);
    end else if (busy_q != 3'h0) begin
      busy_q <= busy_q - 3'h1;
    end
  end

  // Mode load only honoured with all banks idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_word <= 14'h0000;
    end else if (exec && cmd_dec == CMD_MODE_LOAD && bank_idle == 4'hF) begin
      mode_word <= {ba, addr};
    end
  end

  // Self refresh state and exit recovery
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      self_refresh <= 1'b0;
      xsr_q <= 3'h0;
    end else if (sr_entry) begin
      self_refresh <= 1'b1;
    end else if (self_refresh && cke) begin
      self_refresh <= 1'b0;
      xsr_q <= 3'(`XSR_CYC - 1);
    end else if (xsr_q != 3'h0) begin
      xsr_q <= xsr_q - 3'h1;
    end
  end

  // Internal refresh pacing while in self refresh
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sr_tmr_q <= 9'h000;
    end else if (!self_refresh || sr_tick) begin
      sr_tmr_q <= 9'h000;
    end else begin
      sr_tmr_q <= sr_tmr_q + 9'h001;
    end
  end

  assign sr_tick = self_refresh && sr_tmr_q == 9'(`SR_INT_CYC - 1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      refresh_row <= 12'h000;
    end else if ((exec && cmd_dec == CMD_REFRESH) || sr_tick) begin
      refresh_row <= refresh_row + 12'h001;
    end
  end

  // Per-bank row state
  assign ap_fire = last && burst_ap_q;

  generate
    for (genvar b = 0; b < 4; b++) begin : g_bank
      assign act_vec[b] = exec && cmd_dec == CMD_ACTIVATE && ba == 2'(b);
      assign pre_vec[b] = (exec && cmd_dec == CMD_PRECHARGE &&
                           (addr[`AP_BIT] || ba == 2'(b))) ||
                          (ap_fire && burst_bank_q == 2'(b)) ||
                          (start && cmd_dec == CMD_WRITE && addr[`AP_BIT] &&
                           len == 9'h001 && ba == 2'(b));
      sdram_bank_ctrl u_bank (
        .clk(clk),
        .resetn(resetn),
        .activate(act_vec[b]),
        .precharge(pre_vec[b]),
        .row_in(addr[`ROW_W-1:0]),
        .row_open(bank_open[b]),
        .idle(bank_idle[b]),
        .row_addr(bank_row[b])
      );
    end
  endgenerate

  // Burst length from the mode word
  always_comb begin
    case (mode_word[`BL_MSB:0])
      3'h0: len = 9'h001;
      3'h1: len = 9'h002;
      3'h2: len = 9'h004;
      3'h3: len = 9'h008;
      `BL_FULL: len = `FULL_PAGE_LEN;
      default: len = 9'h001;
    endcase
  end

  // Access only to a bank with an open row
  assign start = exec && (cmd_dec == CMD_READ || cmd_dec == CMD_WRITE) && bank_open[ba];
  assign term = exec && cmd_dec == CMD_TERMINATE;
  assign last = burst_on_q && burst_left_q == 9'h001;

  // Burst engine
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      burst_on_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_ap_q <= 1'b0;
      burst_bank_q <= 2'h0;
      burst_col_q <= 8'h00;
      burst_left_q <= 9'h000;
    end else if (start) begin
      burst_wr_q <= cmd_dec == CMD_WRITE;
      burst_ap_q <= addr[`AP_BIT];
      burst_bank_q <= ba;
      if (cmd_dec == CMD_WRITE) begin
        burst_on_q <= len != 9'h001;
        burst_col_q <= addr[`COL_MSB:0] + 8'h01;
        burst_left_q <= len - 9'h001;
      end else begin
        burst_on_q <= 1'b1;
        burst_col_q <= addr[`COL_MSB:0];
        burst_left_q <= len;
      end
    end else if (term || (burst_on_q && pre_vec[burst_bank_q] && !ap_fire)) begin
      burst_on_q <= 1'b0;
    end else if (burst_on_q) begin
      burst_on_q <= !last;
      burst_col_q <= burst_col_q + 8'h01;
      burst_left_q <= burst_left_q - 9'h001;
    end
  end

  // Storage window indexed by bank, low row bits and column
  assign wr_en = (start && cmd_dec == CMD_WRITE) || (burst_on_q && burst_wr_q);
  assign wr_idx = (start && cmd_dec == CMD_WRITE) ?
                  {ba, bank_row[ba][1:0], addr[`COL_MSB:0]} :
                  {burst_bank_q, bank_row[burst_bank_q][1:0], burst_col_q};
  assign rd_idx = {burst_bank_q, bank_row[burst_bank_q][1:0], burst_col_q};

  generate
    for (genvar g = 0; g < 4; g++) begin : g_lane
      logic [7:0] lane_mem [1 << `MEM_AW];
      always_ff @(posedge clk) begin
        if (wr_en && !dqm[g]) begin
          lane_mem[wr_idx] <= dq_in[8*g +: 8];
        end
      end
      assign rd_word[8*g +: 8] = lane_mem[rd_idx];
    end
  endgenerate

  // Read pipeline and delayed output mask
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_v1_q <= 1'b0;
      rd_s1_q <= 32'h00000000;
      dqm_d1_q <= 4'hF;
      dqm_d2_q <= 4'hF;
    end else begin
      rd_v1_q <= burst_on_q && !burst_wr_q && !start && !term;
      rd_s1_q <= rd_word;
      dqm_d1_q <= dqm;
      dqm_d2_q <= dqm_d1_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_out <= 32'h00000000;
      dq_oe_n <= 4'hF;
    end else begin
      dq_out <= rd_s1_q;
      dq_oe_n <= ~({4{rd_v1_q}} & ~dqm_d2_q);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_DESELECT_IDLE: assert property (cmd.cs_n && !self_refresh |=>
    $stable(mode_word) && $stable(refresh_row))
    else $error("deselect changed device state");
  AST_NOP_IDLE: assert property (cmd_dec == CMD_NOP && !burst_on_q |=>
    $stable(mode_word) && $stable(bank_open))
    else $error("nop changed device state");
  AST_MODE_LOAD: assert property (exec && cmd_dec == CMD_MODE_LOAD && bank_idle == 4'hF |=>
    mode_word == {$past(ba), $past(addr)})
    else $error("mode word not loaded");
  AST_ACT_OPENS: assert property (exec && cmd_dec == CMD_ACTIVATE && bank_idle[ba] |=>
    bank_open[$past(ba)] && bank_row[$past(ba)] == $past(addr))
    else $error("activate did not open row");
  AST_READ_DRIVES: assert property (start && cmd_dec == CMD_READ && dqm == 4'h0 ##1
    dqm == 4'h0 && !term && !start |=> ##1 dq_oe_n == 4'h0)
    else $error("read data not driven at latency two");
  AST_DQM_READ: assert property (dqm_d2_q == 4'hF |=> dq_oe_n == 4'hF)
    else $error("masked read lane driven");
  AST_AP_CLOSES: assert property (ap_fire |=> !bank_open[$past(burst_bank_q)])
    else $error("auto precharge left row open");
  AST_PRE_ALL: assert property (exec && cmd_dec == CMD_PRECHARGE && addr[`AP_BIT] |=>
    bank_open == 4'h0)
    else $error("precharge all left a row open");
  AST_TERMINATE: assert property (term |=> !burst_on_q)
    else $error("burst survived terminate");
  AST_REF_ROW: assert property (exec && cmd_dec == CMD_REFRESH |=>
    refresh_row == $past(refresh_row) + 12'h001)
    else $error("refresh row did not advance");
  AST_SR_ENTRY: assert property (sr_entry |=> self_refresh)
    else $error("self refresh not entered");
  AST_NO_SR_AUTO: assert property (automotive_grade && !self_refresh |=> !self_refresh)
    else $error("automotive grade entered self refresh");

  COV_READ: cover property (start && cmd_dec == CMD_READ ##3 dq_oe_n == 4'h0);
  COV_WRITE: cover property (start && cmd_dec == CMD_WRITE && len != 9'h001);
  COV_SELF_REFRESH: cover property (self_refresh ##1 !self_refresh);
  COV_PRE_ALL: cover property (exec && cmd_dec == CMD_PRECHARGE && addr[`AP_BIT]);

endmodule

// [design/sdram_defines.svh]
`ifndef SDRAM_DEFINES_SVH
`define SDRAM_DEFINES_SVH

`define CLK_PERIOD_NS 50
`define T_RP_NS 20
`define RP_CYC ((`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RFC_NS 66
`define RFC_CYC ((`T_RFC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MRD_CYC 2
`define T_XSR_NS 70
`define XSR_NS_CYC ((`T_XSR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define XSR_CYC ((`XSR_NS_CYC > 2) ? `XSR_NS_CYC : 2)
`define SR_INT_NS 15625
`define SR_INT_CYC (`SR_INT_NS / `CLK_PERIOD_NS)
`define AP_BIT 10
`define COL_MSB 7
`define BL_MSB 2
`define BL_FULL 3'h7
`define FULL_PAGE_LEN 9'h100
`define MEM_AW 12
`define ROW_W 12
`define COL_W 8

`endif

// [design/sdram_pkg.sv]
package sdram_pkg;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_pins_t;

  typedef enum logic [3:0] {
    CMD_DESELECT = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACTIVATE = 4'h2,
    CMD_READ = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_TERMINATE = 4'h5,
    CMD_PRECHARGE = 4'h6,
    CMD_REFRESH = 4'h7,
    CMD_MODE_LOAD = 4'h8
  } cmd_t;

  typedef enum logic [1:0] {
    BANK_IDLE = 2'h0,
    BANK_ACTIVE = 2'h1,
    BANK_PRECHARGING = 2'h2
  } bank_state_t;

endpackage

// [sim/sdram_ctrl_model.sv]
`timescale 1ns/1ps

module sdram_ctrl_model
  import sdram_pkg::*;
(
  input wire logic clk,
  output logic cke,
  output cmd_pins_t cmd,
  output logic [1:0] ba,
  output logic [11:0] addr,
  output logic [3:0] dqm,
  output logic [31:0] dq_in,
  output logic automotive_grade
);
  initial begin
    cke = 1'b1;
    cmd = 4'h7;
    ba = 2'h0;
    addr = 12'h000;
    dqm = 4'h0;
    dq_in = 32'h0;
    automotive_grade = 1'b0;
  end

  // Strobe patterns, deselect carries a row-open pattern behind it
  function automatic cmd_pins_t enc(input cmd_t c);
    case (c)
      CMD_DESELECT: enc = 4'hB;
      CMD_ACTIVATE: enc = 4'h3;
      CMD_READ: enc = 4'h5;
      CMD_WRITE: enc = 4'h4;
      CMD_TERMINATE: enc = 4'h6;
      CMD_PRECHARGE: enc = 4'h2;
      CMD_REFRESH: enc = 4'h1;
      CMD_MODE_LOAD: enc = 4'h0;
      default: enc = 4'h7;
    endcase
  endfunction

  // Pins change after the falling edge and hold until the next one
  task automatic issue(input cmd_t c, input logic [1:0] b, input logic [11:0] a,
                       input logic [3:0] m, input logic [31:0] d);
    @(negedge clk);
    cmd = enc(c);
    ba = b;
    addr = a;
    dqm = m;
    dq_in = d;
  endtask

  // Idle cycles, released lines show the inverse of their last value
  task automatic nop(input int n);
    repeat (n) issue(CMD_NOP, ~ba, ~addr, 4'h0, ~dq_in);
  endtask

  // Mode load only with all banks idle, then the settle gap
  task automatic load_mode(input logic [11:0] a);
    issue(CMD_MODE_LOAD, 2'h0, a, 4'h0, 32'h0);
    nop(2);
  endtask

  // Close every bank, then refresh once the precharge period has passed
  task automatic refresh_all(input int n);
    issue(CMD_PRECHARGE, ba, 12'h400, 4'h0, dq_in);
    repeat (n) begin
      issue(CMD_REFRESH, ~ba, ~addr, 4'h0, ~dq_in);
      nop(1);
    end
  endtask

  // The clock never stops, so it is stable before clock enable rises
  task automatic level(input logic k, input logic g);
    @(negedge clk);
    cke = k;
    automotive_grade = g;
  endtask
endmodule

// [sim/tb_sdram_command_protocol.sv]
`timescale 1ns/1ps

module tb_sdram_command_protocol
  import sdram_pkg::*;
;
  logic clk;
  logic resetn;
  logic cke;
  cmd_pins_t cmd;
  logic [1:0] ba;
  logic [11:0] addr;
  logic [3:0] dqm;
  logic [31:0] dq_in;
  logic automotive_grade;
  logic [31:0] dq_out;
  logic [3:0] dq_oe_n;
  logic self_refresh;
  logic [11:0] refresh_row;
  logic [13:0] mode_word;
  logic [3:0] bank_open;
  logic [31:0] rw0;
  logic [31:0] rw1;
  logic [3:0] ro0;
  logic [3:0] ro1;
  logic [11:0] r0;
  int bad_count = 0;
  int check_count = 0;

  sdram_command_protocol i_dut (.clk(clk), .resetn(resetn), .cke(cke), .cmd(cmd),
    .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in), .automotive_grade(automotive_grade),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .self_refresh(self_refresh),
    .refresh_row(refresh_row), .mode_word(mode_word), .bank_open(bank_open));

  sdram_ctrl_model i_ctrl (.clk(clk), .cke(cke), .cmd(cmd), .ba(ba), .addr(addr),
    .dqm(dqm), .dq_in(dq_in), .automotive_grade(automotive_grade));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Read with deselect fillers, second word mask given one edge after the command
  task automatic rd(input logic [1:0] b, input logic [11:0] a, input logic [3:0] m1);
    i_ctrl.issue(CMD_READ, b, a, 4'h0, {~a, ~a, ~a[7:0]});
    i_ctrl.issue(CMD_DESELECT, ~b, ~a, m1, {a, ~a, a[7:0]});
    i_ctrl.issue(CMD_DESELECT, ~b, a ^ 12'h3FF, 4'h0, {~a, a, ~a[7:0]});
    i_ctrl.issue(CMD_DESELECT, b ^ 2'h1, ~a, 4'h0, {a, a, ~a[7:0]});
    rw0 = dq_out;
    ro0 = dq_oe_n;
    i_ctrl.issue(CMD_DESELECT, 2'h2, 12'h000, 4'h0, 32'h0);
    rw1 = dq_out;
    ro1 = dq_oe_n;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    final_report();
  end

  initial begin
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    i_ctrl.load_mode(12'h001);
    chk(mode_word, 14'h0001);
    i_ctrl.issue(CMD_ACTIVATE, 2'h1, 12'h005, 4'h0, 32'h0);
    i_ctrl.issue(CMD_WRITE, 2'h1, 12'h008, 4'h0, 32'hA1A2A3A4);
    i_ctrl.issue(CMD_NOP, 2'h0, 12'h000, 4'h0, 32'hB1B2B3B4);
    i_ctrl.issue(CMD_WRITE, 2'h1, 12'h009, 4'h1, 32'hC1C2C3C4);
    i_ctrl.issue(CMD_NOP, 2'h0, 12'h000, 4'h0, 32'hD1D2D3D4);
    i_ctrl.nop(1);
    rd(2'h1, 12'h008, 4'h0);
    chk(rw0, 32'hA1A2A3A4);
    chk(rw1, 32'hC1C2C3B4);
    chk(ro1, 4'h0);
    rd(2'h1, 12'h40A, 4'hC);
    chk(rw0, 32'hD1D2D3D4);
    chk(ro0, 4'h0);
    chk(ro1, 4'hC);
    i_ctrl.nop(3);
    chk(bank_open, 4'h0);
    $display("Test write_read_mask done");
    i_ctrl.issue(CMD_ACTIVATE, 2'h0, 12'h010, 4'h0, 32'h0);
    i_ctrl.issue(CMD_ACTIVATE, 2'h2, 12'h020, 4'h0, 32'h0);
    i_ctrl.nop(1);
    chk(bank_open, 4'h5);
    i_ctrl.issue(CMD_MODE_LOAD, 2'h0, 12'h003, 4'h0, 32'h0);
    i_ctrl.nop(2);
    chk(mode_word, 14'h0001);
    i_ctrl.issue(CMD_PRECHARGE, 2'h0, 12'h000, 4'h0, 32'h0);
    i_ctrl.nop(1);
    chk(bank_open, 4'h4);
    rd(2'h0, 12'h000, 4'h0);
    chk(ro0, 4'hF);
    chk(ro1, 4'hF);
    i_ctrl.issue(CMD_PRECHARGE, 2'h1, 12'h400, 4'h0, 32'h0);
    i_ctrl.nop(1);
    chk(bank_open, 4'h0);
    $display("Test bank_precharge done");
    i_ctrl.load_mode(12'h003);
    chk(mode_word, 14'h0003);
    i_ctrl.issue(CMD_ACTIVATE, 2'h3, 12'h001, 4'h0, 32'h0);
    i_ctrl.issue(CMD_READ, 2'h3, 12'h000, 4'h0, 32'h0);
    i_ctrl.nop(1);
    i_ctrl.issue(CMD_TERMINATE, 2'h0, 12'h000, 4'h0, 32'h0);
    i_ctrl.nop(1);
    chk(dq_oe_n, 4'h0);
    i_ctrl.nop(5);
    chk(dq_oe_n, 4'hF);
    i_ctrl.issue(CMD_PRECHARGE, 2'h0, 12'h400, 4'h0, 32'h0);
    i_ctrl.nop(1);
    $display("Test terminate done");
    r0 = refresh_row;
    i_ctrl.issue(CMD_REFRESH, 2'h3, 12'hFFF, 4'h0, 32'h0);
    i_ctrl.nop(2);
    i_ctrl.issue(CMD_REFRESH, 2'h0, 12'h000, 4'h0, 32'h0);
    i_ctrl.nop(2);
    chk(refresh_row, r0 + 12'h002);
    chk(self_refresh, 1'b0);
    r0 = refresh_row;
    i_ctrl.refresh_all(4);
    chk(refresh_row, r0 + 12'h004);
    i_ctrl.nop(300);
    i_ctrl.refresh_all(1);
    chk(refresh_row, r0 + 12'h005);
    $display("Test auto_refresh done");
    i_ctrl.level(1'b0, 1'b0);
    i_ctrl.issue(CMD_REFRESH, 2'h0, 12'h000, 4'h0, 32'h0);
    i_ctrl.nop(1);
    chk(self_refresh, 1'b1);
    r0 = refresh_row;
    i_ctrl.issue(CMD_ACTIVATE, 2'h0, 12'h010, 4'h0, 32'h0);
    i_ctrl.nop(330);
    chk(bank_open, 4'h0);
    chk(refresh_row !== r0, 1'b1);
    i_ctrl.level(1'b1, 1'b0);
    i_ctrl.nop(2);
    chk(self_refresh, 1'b0);
    r0 = refresh_row;
    i_ctrl.issue(CMD_REFRESH, 2'h0, 12'h000, 4'h0, 32'h0);
    i_ctrl.nop(2);
    chk(refresh_row, r0 + 12'h001);
    i_ctrl.level(1'b0, 1'b1);
    i_ctrl.issue(CMD_REFRESH, 2'h0, 12'h000, 4'h0, 32'h0);
    i_ctrl.nop(2);
    chk(self_refresh, 1'b0);
    i_ctrl.level(1'b1, 1'b0);
    i_ctrl.nop(1);
    $display("Test self_refresh done");
    final_report();
  end
endmodule
